// >>> common/np_pkg.sv
package np_pkg;
  // ==========================================================
  // register map
  localparam logic [15:0] NP_TX_OFFSET = 16'h4220;
  localparam logic [15:0] NP_RX_OFFSET = 16'h4224;
  localparam logic [31:0] NP_TX_RESET = 32'h0000_0000;
  localparam logic [31:0] NP_RX_RESET = 32'h0000_0000;
  // ==========================================================
  // link code word fields
  localparam int CODE_LSB = 0;
  localparam int CODE_MSB = 10;
  localparam int TOGGLE_BIT = 11;
  localparam int SECOND_ACK_BIT = 12;
  localparam int PAGE_KIND_BIT = 13;
  localparam int ACK_BIT = 14;
  localparam int MORE_PAGES_BIT = 15;
  localparam int WORD_W = 16;
  localparam logic PAGE_UNFORMATTED = 1'b0;
  localparam logic PAGE_MESSAGE = 1'b1;
  // bits that software may write into the outgoing register
  localparam logic [31:0] NP_TX_WMASK = 32'h0000_B7FF;
  // ==========================================================
  // negotiation states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_BASE = 4'h2,
    ST_NEXT = 4'h4,
    ST_DONE = 4'h8
  } neg_state_type;
endpackage

// >>> common/np_link_if.sv
`timescale 1ns/10ps
interface np_link_if;
  logic [15:0] dev_word;
  logic dev_valid;
  logic [15:0] ptn_word;
  logic ptn_valid;
  modport device (output dev_word, output dev_valid, input ptn_word, input ptn_valid);
  modport partner (input dev_word, input dev_valid, output ptn_word, output ptn_valid);
endinterface

// >>> hw/np_partner.sv
`timescale 1ns/10ps
module np_partner (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic CLK_EN,
  input wire logic [15:0] BASE_PAGE,
  input wire logic [15:0] PAGE_IN,
  input wire logic PAGE_LOAD,
  output logic [15:0] PAGE_OUT,
  output logic PAGE_OUT_VALID,
  output logic TOGGLE_ERROR,
  output logic NEG_DONE,
  np_link_if.partner link
);
  typedef struct packed {
    np_pkg::neg_state_type st;
    logic [15:0] tx_word;
    logic tx_valid;
    logic [15:0] rx_word;
    logic rx_valid;
    logic last_tx_toggle;
    logic last_rx_toggle;
    logic got;
    logic sent;
    logic terr;
  } state_type;
  state_type s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tx_valid = 1'b0;
    s_nxt.rx_valid = 1'b0;
    case (s_r.st)
      np_pkg::ST_IDLE: begin
        if (link.dev_valid) begin
          // reply to the device base page with our own
          s_nxt.tx_word = BASE_PAGE;
          s_nxt.tx_word[np_pkg::ACK_BIT] = 1'b1;
          s_nxt.tx_valid = 1'b1;
          s_nxt.last_tx_toggle = BASE_PAGE[np_pkg::TOGGLE_BIT];
          s_nxt.last_rx_toggle = link.dev_word[np_pkg::TOGGLE_BIT];
          if (BASE_PAGE[np_pkg::MORE_PAGES_BIT] && link.dev_word[np_pkg::MORE_PAGES_BIT]) begin
            s_nxt.st = np_pkg::ST_NEXT;
          end else begin
            s_nxt.st = np_pkg::ST_DONE;
          end
        end
      end
      np_pkg::ST_NEXT: begin
        if (PAGE_LOAD && !s_r.sent) begin
          s_nxt.tx_word = PAGE_IN;
          s_nxt.tx_word[np_pkg::TOGGLE_BIT] = ~s_r.last_tx_toggle;
          s_nxt.tx_word[np_pkg::ACK_BIT] = s_r.got;
          s_nxt.tx_word[np_pkg::SECOND_ACK_BIT] = PAGE_IN[np_pkg::SECOND_ACK_BIT];
          s_nxt.tx_valid = 1'b1;
          s_nxt.last_tx_toggle = ~s_r.last_tx_toggle;
          s_nxt.sent = 1'b1;
        end
        if (link.dev_valid) begin
          if (link.dev_word[np_pkg::TOGGLE_BIT] == ~s_r.last_rx_toggle) begin
            s_nxt.rx_word = link.dev_word;
            s_nxt.rx_valid = 1'b1;
            s_nxt.last_rx_toggle = ~s_r.last_rx_toggle;
            s_nxt.got = 1'b1;
          end else begin
            s_nxt.terr = 1'b1;
          end
        end
        if (s_r.sent && s_r.got) begin
          s_nxt.sent = 1'b0;
          s_nxt.got = 1'b0;
          if (!s_r.tx_word[np_pkg::MORE_PAGES_BIT] && !s_r.rx_word[np_pkg::MORE_PAGES_BIT]) begin
            s_nxt.st = np_pkg::ST_DONE;
          end
        end
      end
      np_pkg::ST_DONE: begin
      end
      default: begin
        s_nxt.st = np_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      s_r <= '{st: np_pkg::ST_IDLE, default: '0};
    end else if (CLK_EN) begin
      s_r <= s_nxt;
    end
  end

  assign link.ptn_word = s_r.tx_word;
  assign link.ptn_valid = s_r.tx_valid;
  assign PAGE_OUT = s_r.rx_word;
  assign PAGE_OUT_VALID = s_r.rx_valid;
  assign TOGGLE_ERROR = s_r.terr;
  assign NEG_DONE = (s_r.st == np_pkg::ST_DONE);
endmodule

// >>> hw/np_device.sv
`timescale 1ns/10ps
module np_device (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic CLK_EN,
  input wire logic START,
  input wire logic [15:0] BASE_PAGE,
  input wire logic REQUEST_PAGES,
  input wire logic [15:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic REG_RVALID,
  output logic EXTRA_PAGES_REQUESTED,
  output logic TOGGLE_ERROR,
  output logic NEG_DONE,
  np_link_if.device link
);
  // ==========================================================
  // state
  typedef struct packed {
    np_pkg::neg_state_type st;
    logic [31:0] np_tx;
    logic [31:0] np_rx;
    logic [15:0] tx_word;
    logic tx_valid;
    logic pend;
    logic req;
    // round bookkeeping: toggle chains and what this round has seen
    logic last_tx_toggle;
    logic last_rx_toggle;
    logic got;
    logic sent;
    logic terr;
    // register read port
    logic [31:0] rdata;
    logic rvalid;
  } state_type;
  state_type s_r, s_nxt;
  logic [31:0] tx_view;
  logic [31:0] rd_mux;
  logic [15:0] base_word;
  logic tx_write;
  logic ptn_fresh;
  logic round_done;
  logic last_round;

  // ==========================================================
  // decode
  always_comb begin
    // the toggle is owned by hardware: software cannot desynchronise the link by writing it
    tx_view = s_r.np_tx;
    tx_view[np_pkg::TOGGLE_BIT] = ~s_r.last_tx_toggle;
    // the base word never carries an acknowledge: nothing has been received yet
    base_word = BASE_PAGE;
    base_word[np_pkg::MORE_PAGES_BIT] = REQUEST_PAGES;
    base_word[np_pkg::ACK_BIT] = 1'b0;
    // only the outgoing register takes writes; other offsets ignore them
    tx_write = REG_WR && (REG_ADDR == np_pkg::NP_TX_OFFSET);
    case (REG_ADDR)
      np_pkg::NP_TX_OFFSET: rd_mux = tx_view;
      np_pkg::NP_RX_OFFSET: rd_mux = s_r.np_rx;
      default: rd_mux = '0;
    endcase
    // a partner page counts only if its toggle moved on from the last one taken
    ptn_fresh = link.ptn_word[np_pkg::TOGGLE_BIT] == ~s_r.last_rx_toggle;
    round_done = s_r.sent && s_r.got;
    // the exchange closes only when both ends have sent their last page
    last_round = !s_r.tx_word[np_pkg::MORE_PAGES_BIT]
                 && !s_r.np_rx[np_pkg::MORE_PAGES_BIT];
  end

  // ==========================================================
  // next state
  always_comb begin
    s_nxt = s_r;
    // strobes last one cycle
    s_nxt.tx_valid = 1'b0;
    s_nxt.rvalid = 1'b0;
    // ==========================================================
    // register port
    // reserved positions are dropped; software is expected to write them zero
    if (tx_write) begin
      s_nxt.np_tx = REG_WDATA & np_pkg::NP_TX_WMASK;
      s_nxt.pend = 1'b1;
    end
    // a read and a write in one cycle: the read returns the old contents
    if (REG_RD) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd_mux;
    end
    // ==========================================================
    // negotiation
    case (s_r.st)
      np_pkg::ST_IDLE: begin
        if (START) begin
          s_nxt.tx_word = base_word;
          // our own base word seeds the transmit toggle chain
          s_nxt.tx_valid = 1'b1;
          s_nxt.req = REQUEST_PAGES;
          s_nxt.last_tx_toggle = BASE_PAGE[np_pkg::TOGGLE_BIT];
          s_nxt.st = np_pkg::ST_BASE;
        end
      end
      np_pkg::ST_BASE: begin
        if (link.ptn_valid) begin
          // the partner base word seeds the receive toggle chain
          s_nxt.last_rx_toggle = link.ptn_word[np_pkg::TOGGLE_BIT];
          // next pages flow only when both ends asked for them
          if (s_r.req && link.ptn_word[np_pkg::MORE_PAGES_BIT]) begin
            s_nxt.st = np_pkg::ST_NEXT;
          end else begin
            s_nxt.req = 1'b0;
            s_nxt.st = np_pkg::ST_DONE;
          end
        end
      end
      np_pkg::ST_NEXT: begin
        // one page per round; a write after the send waits for the next round
        if (s_r.pend && !s_r.sent) begin
          s_nxt.tx_word = tx_view[np_pkg::WORD_W-1:0];
          // acknowledge tells whether this round's partner page has arrived
          s_nxt.tx_word[np_pkg::ACK_BIT] = s_r.got;
          s_nxt.tx_valid = 1'b1;
          s_nxt.last_tx_toggle = ~s_r.last_tx_toggle;
          s_nxt.sent = 1'b1;
          // a write landing in this very cycle arms the next page and must not be lost
          if (!tx_write) begin
            s_nxt.pend = 1'b0;
          end
          // advertise no more pages once the last one is out
          if (!s_r.np_tx[np_pkg::MORE_PAGES_BIT]) begin
            s_nxt.req = 1'b0;
          end
        end
        if (link.ptn_valid) begin
          // a page with a stale toggle is a repeat or a slip; it is not taken
          if (ptn_fresh) begin
            s_nxt.np_rx = {16'h0000, link.ptn_word};
            s_nxt.last_rx_toggle = ~s_r.last_rx_toggle;
            s_nxt.got = 1'b1;
          end else begin
            s_nxt.terr = 1'b1;
          end
        end
        if (round_done) begin
          s_nxt.sent = 1'b0;
          s_nxt.got = 1'b0;
          if (last_round) begin
            s_nxt.st = np_pkg::ST_DONE;
          end
        end
      end
      np_pkg::ST_DONE: begin
        // registers keep their contents across a restart
        if (START) begin
          s_nxt.st = np_pkg::ST_IDLE;
          s_nxt.terr = 1'b0;
        end
      end
      default: begin
        // an illegal state code falls back to idle
        s_nxt.st = np_pkg::ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      s_r <= '{
        st: np_pkg::ST_IDLE,
        np_tx: np_pkg::NP_TX_RESET,
        np_rx: np_pkg::NP_RX_RESET,
        // shows a zero toggle in the outgoing register until a base page seeds it
        last_tx_toggle: 1'b1,
        default: '0
      };
    end else if (CLK_EN) begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  // NEG_DONE stays up until the next START
  assign link.dev_word = s_r.tx_word;
  assign link.dev_valid = s_r.tx_valid;
  assign REG_RDATA = s_r.rdata;
  assign REG_RVALID = s_r.rvalid;
  assign EXTRA_PAGES_REQUESTED = s_r.req;
  assign TOGGLE_ERROR = s_r.terr;
  assign NEG_DONE = (s_r.st == np_pkg::ST_DONE);
endmodule

// >>> testbench/np_link_assertions.sv
`timescale 1ns/10ps
module np_link_assertions (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic [15:0] dev_word,
  input wire logic dev_valid,
  input wire logic [15:0] ptn_word,
  input wire logic ptn_valid
);
  logic dev_seen_r;
  logic ptn_seen_r;
  logic dev_tog_r;
  logic ptn_tog_r;
  // ==========================================================
  // last toggle sent by each end; the base word seeds the chain
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      dev_seen_r <= 1'h0;
      ptn_seen_r <= 1'h0;
      dev_tog_r <= 1'h0;
      ptn_tog_r <= 1'h0;
    end else begin
      dev_seen_r <= dev_seen_r | dev_valid;
      ptn_seen_r <= ptn_seen_r | ptn_valid;
      dev_tog_r <= dev_valid ? dev_word[11] : dev_tog_r;
      ptn_tog_r <= ptn_valid ? ptn_word[11] : ptn_tog_r;
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  sequence dev_base_s;
    !dev_seen_r && dev_valid;
  endsequence
  dev_pulse_a: assert property (dev_valid |=> !dev_valid)
    else $error("device word valid too long");
  ptn_pulse_a: assert property (ptn_valid |=> !ptn_valid)
    else $error("partner word valid too long");
  base_reply_a: assert property (dev_base_s |=> ptn_valid)
    else $error("base page not answered");
  dev_base_ack_a: assert property (dev_base_s |-> !dev_word[14])
    else $error("device base carries acknowledge");
  ptn_base_ack_a: assert property (!ptn_seen_r && ptn_valid |-> ptn_word[14])
    else $error("partner base lacks acknowledge");
  dev_toggle_a: assert property (dev_seen_r && dev_valid |-> dev_word[11] != dev_tog_r)
    else $error("device toggle did not flip");
  ptn_toggle_a: assert property (ptn_seen_r && ptn_valid |-> ptn_word[11] != ptn_tog_r)
    else $error("partner toggle did not flip");
  dev_hold_a: assert property (!dev_valid && !$past(RESET) |-> $stable(dev_word))
    else $error("device word changed without valid");
  base_first_a: assert property (ptn_valid |-> dev_seen_r)
    else $error("partner sent before device base");
endmodule

// >>> testbench/autoneg_next_page_exchange_tb.sv
`timescale 1ns/10ps
module autoneg_next_page_exchange_tb;
  logic sys_clk = 1'h0;
  logic reset = 1'h1;
  logic start = 1'h0;
  logic [15:0] dev_base = 16'h0000;
  logic [15:0] ptn_base = 16'h8000;
  logic [15:0] page_in = 16'h0000;
  logic page_load = 1'h0;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr = 1'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_rd = 1'h0;
  logic clk_en = 1'h1;
  logic req_pages = 1'h1;
  logic [31:0] reg_rdata;
  logic [15:0] page_out;
  logic [15:0] got_page;
  logic reg_rvalid, extra_req, dev_terr, dev_done, ptn_terr, ptn_done, page_out_valid;
  logic [31:0] lfsr = 32'h89BBCF8C;
  logic [31:0] rd;
  logic [31:0] d;
  logic dtog, ptog;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int dev_cnt = 0;
  int ptn_cnt = 0;
  np_link_if np_link_if_inst ();
  np_device np_device_inst (.SYS_CLK(sys_clk), .RESET(reset), .CLK_EN(clk_en), .START(start),
    .BASE_PAGE(dev_base), .REQUEST_PAGES(req_pages), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
    .REG_WDATA(reg_wdata), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
    .EXTRA_PAGES_REQUESTED(extra_req), .TOGGLE_ERROR(dev_terr), .NEG_DONE(dev_done),
    .link(np_link_if_inst.device));
  np_partner np_partner_inst (.SYS_CLK(sys_clk), .RESET(reset), .CLK_EN(clk_en),
    .BASE_PAGE(ptn_base), .PAGE_IN(page_in), .PAGE_LOAD(page_load), .PAGE_OUT(page_out),
    .PAGE_OUT_VALID(page_out_valid), .TOGGLE_ERROR(ptn_terr), .NEG_DONE(ptn_done),
    .link(np_link_if_inst.partner));
  np_link_assertions np_link_assertions_inst (.SYS_CLK(sys_clk), .RESET(reset),
    .dev_word(np_link_if_inst.dev_word), .dev_valid(np_link_if_inst.dev_valid),
    .ptn_word(np_link_if_inst.ptn_word), .ptn_valid(np_link_if_inst.ptn_valid));
  initial forever #5 sys_clk = ~sys_clk;
  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected page: toggle and acknowledge belong to hardware
  function automatic logic [31:0] exp_pg(input logic [15:0] w, input logic t, input logic a);
    return {16'h0000, w[15], a, w[13:12], t, w[10:0]};
  endfunction
  task tick;
    @(posedge sys_clk);
    #1;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task reg_access(input logic w, input logic [15:0] a, input logic [31:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = w;
    reg_rd = !w;
    tick;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    for (int i = 0; i < 4 && !w && reg_rvalid !== 1'h1; i++) tick;
    rd = reg_rdata;
    tick;
  endtask
  task stop_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (page_out_valid === 1'h1) begin
      got_page <= page_out;
      dev_cnt++;
    end
    if (np_link_if_inst.ptn_valid === 1'h1) ptn_cnt++;
    if (cycles == 3000) begin
      num_errors++;
      stop_test;
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (6) tick;
    reset = 1'h0;
    reg_access(1'h0, 16'h4220, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    reg_access(1'h0, 16'h4224, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    reg_access(1'h0, 16'h4228, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    $display("reset test done");
    lfsr = rnd(lfsr);
    dev_base = lfsr[15:0];
    ptn_base = {1'h1, lfsr[30:16]};
    dtog = ~dev_base[11];
    ptog = ~ptn_base[11];
    start = 1'h1;
    tick;
    start = 1'h0;
    repeat (4) tick;
    check({31'h0, extra_req}, 32'h0000_0001);
    for (int k = 0; k < 4; k++) begin
      lfsr = rnd(lfsr);
      d = {16'h0000, k < 3, 1'h0, lfsr[13:11], k == 0 ? 11'h7FF : k == 1 ? 11'h000 : lfsr[10:0]};
      page_in = {k < 3, lfsr[30:16]};
      if (k % 2) reg_access(1'h1, 16'h4220, d);
      if (k % 2) repeat (2) tick;
      page_load = 1'h1;
      tick;
      page_load = 1'h0;
      if (!(k % 2)) reg_access(1'h1, 16'h4220, d);
      for (int i = 0; i < 20 && (dev_cnt < k + 1 || ptn_cnt < k + 2); i++) tick;
      check({16'h0000, got_page & 16'hBFFF}, exp_pg(d[15:0], dtog, 1'h0));
      reg_access(1'h0, 16'h4224, 32'h0000_0000);
      check(rd, exp_pg(page_in, ptog, k % 2 == 1));
      dtog = ~dtog;
      ptog = ~ptog;
    end
    $display("page rounds done");
    for (int i = 0; i < 20 && !(dev_done === 1'h1 && ptn_done === 1'h1); i++) tick;
    check({27'h0, dev_done, ptn_done, dev_terr, ptn_terr, extra_req}, 32'h0000_0018);
    lfsr = rnd(lfsr);
    reg_access(1'h1, 16'h4220, lfsr & 32'h0000_B7FF);
    reg_access(1'h0, 16'h4220, 32'h0000_0000);
    check(rd & 32'hFFFF_F7FF, lfsr & 32'h0000_B7FF);
    $display("register test done");
    reset = 1'h1;
    repeat (2) tick;
    reset = 1'h0;
    reg_access(1'h0, 16'h4220, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    req_pages = 1'h0;
    clk_en = 1'h0;
    start = 1'h1;
    repeat (3) tick;
    check({30'h0, dev_done, np_link_if_inst.dev_valid}, 32'h0000_0000);
    clk_en = 1'h1;
    tick;
    start = 1'h0;
    for (int i = 0; i < 20 && !(dev_done === 1'h1 && ptn_done === 1'h1); i++) tick;
    check({27'h0, dev_done, ptn_done, dev_terr, ptn_terr, extra_req}, 32'h0000_0018);
    $display("no next page test done");
    stop_test;
  end
endmodule
